// >>> rtl/wwdt_cfg_defs.svh
// constants for the windowed watchdog configuration decode block
`ifndef WWDT_CFG_DEFS_SVH
`define WWDT_CFG_DEFS_SVH
`define ADDR_CFG_WORD     12'h000
`define ADDR_RUN_CTRL0    12'h004
`define ADDR_RUN_CTRL1    12'h008
`define ADDR_CLEAR        12'h00C
`define ADDR_COUNT        12'h010
`define ADDR_IRQ_STATUS   12'h014
`define ADDR_IRQ_MASK     12'h018
`define CFG_WORD_RESET    16'hFFFF
`define CFG_CCS_LSB       11
`define CFG_CWS_LSB       8
`define CFG_MODE_LSB      5
`define CFG_CPS_LSB       0
`define CTRL0_ENABLE_BIT  0
`define CTRL0_PS_LSB      1
`define PS_POR_VALUE      5'h0B
`define PS_SOFT_CODE      5'h1F
`define PS_MAX_CODE       5'h12
`define PS_EXP_OFFSET     5'h05
`define WIN_SOFT_MIN      3'h6
`define CLEAR_KEY         32'h0000_5A5A
`define CCS_SOFT          3'h7
`define CCS_XTAL          3'h2
`define CCS_MFINT         3'h1
`define CCS_LFINT         3'h0
`define FIN_KHZ_LF        310
`define FIN_KHZ_MF        3125
`define FIN_KHZ_XTAL      320
`define CLK_SYS_KHZ       250000
`define REF_DIV_DEFAULT   32'd8064
`endif

// >>> rtl/wwdt_cfg_pkg.sv
// types for the windowed watchdog configuration decode block
`default_nettype none
package wwdt_cfg_pkg;
  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_SOFT,
    MODE_AWAKE,
    MODE_ALWAYS
  } wdt_mode_e;
  typedef logic [4:0] period_code_t;
endpackage
`default_nettype wire

// >>> rtl/wwdt_cfg_decode.sv
// windowed watchdog: configuration decode, counter, apb registers
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_cfg_defs.svh"
// Notes on behaviour
// (RULE1) window codes 111/110 are fully open and soft-writable, lower codes close 25..87.5 percent, fixed, keyed.
// (RULE2) mode 11 runs always, sleep included, ignoring the software enable.
// (RULE3) mode 10 counts only while awake, holding during sleep, ignoring the software enable.
// (RULE4) mode 01 runs or stops from the software enable bit.
// (RULE5) mode 00 keeps the watchdog off whatever the software enable holds.
// (RULE6) period codes 0..18 divide by two to the (code+5), and code 19 divides by 32.
// (RULE7) period code 31 gives software the period, loaded with 01011 at reset; other codes fix it.
// (RULE8) the time-out lasts the divider ratio in reference clock cycles.
// (RULE9) the reference select picks software, crystal, mid or low internal oscillator; 011..110 reserved.
// (RULE10) a reset is raised at period end without a clear, or on a clear while the window is closed.
module wwdt_cfg_decode (
  // clock and reset
  input  wire logic                       clk_sys_i,
  input  wire logic                       reset_i,
  // configuration and core state
  input  wire logic [15:0]                cfg_word_i,
  input  wire logic                       sleep_i,
  // apb slave
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [11:0]                paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  // watchdog results
  output logic                            wdt_reset_o,
  output logic                            irq_o,
  output wwdt_cfg_pkg::period_code_t      period_code_o
);
  import wwdt_cfg_pkg::*;

  typedef struct packed {
    logic [15:0]  cfg;
    logic         loaded;
    logic         soft_en;
    period_code_t ps;
    logic [2:0]   win;
    logic [2:0]   ccs_soft;
    logic [31:0]  refdiv;
    logic [23:0]  count;
    logic         wdt_reset;
    logic [1:0]   irq_status;
    logic [1:0]   irq_mask;
    logic [31:0]  rdata;
  } state_s;

  state_s state;
  state_s next_state;

  localparam int unsigned REF_DIV = `REF_DIV_DEFAULT;

  function automatic logic [4:0] div_exponent(input period_code_t c);
    if (c <= `PS_MAX_CODE) begin // RULE6
      div_exponent = c + `PS_EXP_OFFSET;
    end else begin
      div_exponent = `PS_EXP_OFFSET; // RULE6
    end
  endfunction

  function automatic logic [23:0] window_open_at(input logic [2:0] w, input logic [4:0] e);
    logic [26:0] full;
    full = 27'(1) << e;
    if (w >= `WIN_SOFT_MIN) begin // RULE1
      window_open_at = '0;
    end else begin
      window_open_at = 24'((full >> 3) * (27'(7) - 27'(w))); // RULE1
    end
  endfunction

  wdt_mode_e   mode;
  logic [2:0]  cfg_cws;
  logic [2:0]  cfg_ccs;
  logic [2:0]  ccs_eff;
  logic        ps_soft;
  logic        win_soft;
  logic        run;
  logic [4:0]  exp_now;
  logic [23:0] limit;
  logic        ref_tick;
  logic        access;
  logic        clr_hit;
  logic        clr_closed;
  logic        timeout;

  always_comb begin
    mode     = wdt_mode_e'(state.cfg[`CFG_MODE_LSB +: 2]);
    cfg_cws  = state.cfg[`CFG_CWS_LSB +: 3];
    cfg_ccs  = state.cfg[`CFG_CCS_LSB +: 3];
    ps_soft  = state.cfg[`CFG_CPS_LSB +: 5] == `PS_SOFT_CODE; // RULE7
    win_soft = cfg_cws >= `WIN_SOFT_MIN; // RULE1
    ccs_eff  = (cfg_ccs == `CCS_SOFT) ? state.ccs_soft : cfg_ccs; // RULE9
    unique case (mode)
      MODE_ALWAYS: run = 1'b1; // RULE2
      MODE_AWAKE:  run = !sleep_i; // RULE3
      MODE_SOFT:   run = state.soft_en; // RULE4
      MODE_OFF:    run = 1'b0; // RULE5
    endcase
    run      = run && state.loaded && (ccs_eff <= `CCS_XTAL); // RULE9
    exp_now  = div_exponent(state.ps);
    limit    = 24'((27'(1) << exp_now) - 27'(1));
    ref_tick = state.refdiv >= 32'(REF_DIV - 1);
    access   = psel_i && penable_i;
    clr_hit  = access && pwrite_i && paddr_i == `ADDR_CLEAR && pwdata_i == `CLEAR_KEY;
    clr_closed = clr_hit && run && state.count < window_open_at(state.win, exp_now);
    timeout  = run && ref_tick && state.count >= limit; // RULE8
  end

  always_comb begin
    next_state = state;
    if (!state.loaded) begin
      next_state.cfg    = cfg_word_i;
      next_state.loaded = 1'b1;
      next_state.ps     = (cfg_word_i[`CFG_CPS_LSB +: 5] == `PS_SOFT_CODE) ?
                          `PS_POR_VALUE : cfg_word_i[`CFG_CPS_LSB +: 5]; // RULE7
      next_state.win    = cfg_word_i[`CFG_CWS_LSB +: 3]; // RULE1
    end
    // reference clock enable, held while stopped so sleep suspends the count
    if (run) begin
      next_state.refdiv = ref_tick ? '0 : state.refdiv + 32'd1;
      if (ref_tick) begin
        next_state.count = timeout ? '0 : state.count + 24'd1; // RULE8
      end
    end
    if (clr_hit) begin
      next_state.count  = '0;
      next_state.refdiv = '0;
    end
    next_state.wdt_reset = timeout || clr_closed; // RULE10
    if (access && pwrite_i) begin
      unique case (paddr_i)
        `ADDR_RUN_CTRL0: begin
          next_state.soft_en = pwdata_i[`CTRL0_ENABLE_BIT]; // RULE4
          if (ps_soft) begin
            next_state.ps = pwdata_i[`CTRL0_PS_LSB +: 5]; // RULE7
          end
        end
        `ADDR_RUN_CTRL1: begin
          if (win_soft) begin
            next_state.win = pwdata_i[2:0]; // RULE1
          end
          next_state.ccs_soft = pwdata_i[6:4];
        end
        `ADDR_IRQ_MASK: next_state.irq_mask = pwdata_i[1:0];
        default: ;
      endcase
    end
    if (access && !pwrite_i && paddr_i == `ADDR_IRQ_STATUS) begin
      next_state.irq_status = '0;
    end
    // set wins over the read clear
    next_state.irq_status = next_state.irq_status | {clr_closed, timeout};
    next_state.rdata = '0;
    if (psel_i && !penable_i && !pwrite_i) begin
      unique case (paddr_i)
        `ADDR_CFG_WORD:   next_state.rdata = {16'h0000, state.cfg};
        `ADDR_RUN_CTRL0:  next_state.rdata = {26'h0, state.ps, state.soft_en};
        `ADDR_RUN_CTRL1:  next_state.rdata = {25'h0, state.ccs_soft, 1'b0, state.win};
        `ADDR_COUNT:      next_state.rdata = {8'h00, state.count};
        `ADDR_IRQ_STATUS: next_state.rdata = {30'h0, state.irq_status};
        `ADDR_IRQ_MASK:   next_state.rdata = {30'h0, state.irq_mask};
        default:          next_state.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // clear register is write-only; any other unmapped address errors
  always_comb begin
    pready_o  = 1'b1;
    pslverr_o = access && (paddr_i > `ADDR_IRQ_MASK || paddr_i[1:0] != 2'b00 ||
                (!pwrite_i && paddr_i == `ADDR_CLEAR));
  end

  assign prdata_o      = state.rdata;
  assign wdt_reset_o   = state.wdt_reset;
  assign irq_o         = |(state.irq_status & state.irq_mask);
  assign period_code_o = state.ps;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  mode_off_a: assert property (state.loaded && mode == MODE_OFF |-> !run) // RULE5
    else $error("watchdog ran in off mode");
  mode_always_a: assert property (state.loaded && mode == MODE_ALWAYS && ccs_eff <= `CCS_XTAL |-> run) // RULE2
    else $error("always mode not running");
  sleep_hold_a: assert property (mode == MODE_AWAKE && sleep_i && !clr_hit |=> $stable(state.count)) // RULE3
    else $error("count moved during sleep");
  soft_enable_a: assert property (state.loaded && mode == MODE_SOFT && ccs_eff <= `CCS_XTAL |-> run == state.soft_en) // RULE4
    else $error("soft mode ignores enable");
  div_fold_a: assert property (state.ps == 5'h13 |-> limit == 24'd31) // RULE6
    else $error("code 19 not 1:32");
  ps_locked_a: assert property (state.loaded && !ps_soft |=> $stable(state.ps)) // RULE7
    else $error("fixed period changed");
  ps_por_a: assert property ($rose(state.loaded) && ps_soft |-> state.ps == 5'h0B) // RULE7
    else $error("soft period reset value wrong");
  win_locked_a: assert property (state.loaded && !win_soft |=> $stable(state.win)) // RULE1
    else $error("fixed window changed");
  reserved_clk_a: assert property (ccs_eff > `CCS_XTAL |-> !run) // RULE9
    else $error("reserved clock ran");
  timeout_rst_a: assert property (timeout |=> wdt_reset_o) // RULE10
    else $error("no reset on timeout");
  early_clear_a: assert property (clr_closed |=> wdt_reset_o && state.irq_status[1]) // RULE10
    else $error("no reset on closed clear");
  count_limit_a: assert property (run && !ps_soft |-> state.count <= limit) // RULE8
    else $error("count past period");

  // counting: one step per reference tick, nothing in between
  count_step_a: assert property (run && ref_tick && !timeout && !clr_hit // RULE8
    |=> state.count == $past(state.count) + 24'd1)
    else $error("count did not step on a tick");
  no_tick_hold_a: assert property (run && !ref_tick && !clr_hit // RULE8
    |=> $stable(state.count))
    else $error("count moved between ticks");
  stopped_hold_a: assert property (state.loaded && !run && !clr_hit // RULE5
    |=> $stable(state.count))
    else $error("stopped watchdog counted");
  timeout_zero_a: assert property (timeout // RULE8
    |=> state.count == 24'h00_0000)
    else $error("count not restarted after timeout");
  clear_zero_a: assert property (clr_hit // RULE10
    |=> state.count == 24'h00_0000)
    else $error("keyed clear left count");
  timeout_status_a: assert property (timeout // RULE10
    |=> state.irq_status[0])
    else $error("timeout status not set");
  status_clear_a: assert property (access && !pwrite_i && paddr_i == `ADDR_IRQ_STATUS && !timeout && !clr_closed
    |=> state.irq_status == 2'b00)
    else $error("status read did not clear");
  no_reset_quiet_a: assert property (!timeout && !clr_closed // RULE10
    |=> !wdt_reset_o)
    else $error("reset without cause");
  sleep_run_a: assert property (state.loaded && mode == MODE_AWAKE && !sleep_i && ccs_eff <= `CCS_XTAL // RULE3
    |-> run)
    else $error("awake mode not running");

  // divider ends and reset code, checked against fixed ratios rather than the shift
  div_min_a: assert property (state.ps == 5'h00 // RULE6
    |-> limit == 24'd31)
    else $error("code 0 not 1:32");
  div_max_a: assert property (state.ps == 5'h12 // RULE6
    |-> limit == 24'h7F_FFFF)
    else $error("code 18 not 1:8388608");
  div_por_a: assert property (state.ps == `PS_POR_VALUE // RULE7
    |-> limit == 24'h00_FFFF)
    else $error("reset period not 1:65536");

  // window: 50 percent code at a 1:512 divider stays closed for 256 ticks
  half_closed_a: assert property (clr_hit && run && state.win == 3'b011 && exp_now == 5'd9 && state.count < 24'd256 // RULE1
    |-> clr_closed)
    else $error("early clear in half window accepted");
  half_open_a: assert property (clr_hit && run && state.win == 3'b011 && exp_now == 5'd9 && state.count >= 24'd256 // RULE1
    |-> !clr_closed)
    else $error("late clear in half window refused");
  open_clear_a: assert property (clr_hit && state.win >= `WIN_SOFT_MIN // RULE1
    |-> !clr_closed)
    else $error("open window refused a clear");
  win_por_a: assert property ($rose(state.loaded) // RULE1
    |-> state.win == state.cfg[`CFG_CWS_LSB +: 3])
    else $error("window not loaded from config");
  ps_fixed_por_a: assert property ($rose(state.loaded) && !ps_soft // RULE7
    |-> state.ps == state.cfg[`CFG_CPS_LSB +: 5])
    else $error("fixed period not loaded from config");
  load_once_a: assert property (state.loaded
    |=> state.loaded && $stable(state.cfg))
    else $error("config reloaded without reset");

  // software fields
  sen_write_a: assert property (access && pwrite_i && paddr_i == `ADDR_RUN_CTRL0 // RULE4
    |=> state.soft_en == $past(pwdata_i[`CTRL0_ENABLE_BIT]))
    else $error("software enable not taken");
  ps_write_a: assert property (state.loaded && ps_soft && access && pwrite_i && paddr_i == `ADDR_RUN_CTRL0 // RULE7
    |=> state.ps == $past(pwdata_i[`CTRL0_PS_LSB +: 5]))
    else $error("soft period not taken");
  win_write_a: assert property (state.loaded && win_soft && access && pwrite_i && paddr_i == `ADDR_RUN_CTRL1 // RULE1
    |=> state.win == $past(pwdata_i[2:0]))
    else $error("soft window not taken");
  ccs_write_a: assert property (access && pwrite_i && paddr_i == `ADDR_RUN_CTRL1 // RULE9
    |=> state.ccs_soft == $past(pwdata_i[6:4]))
    else $error("soft clock select not taken");
  mask_write_a: assert property (access && pwrite_i && paddr_i == `ADDR_IRQ_MASK
    |=> state.irq_mask == $past(pwdata_i[1:0]))
    else $error("mask not taken");
  irq_masked_a: assert property (state.irq_mask == 2'b00
    |-> !irq_o)
    else $error("masked interrupt raised");

  // apb slave: zero wait states, errors only in the access phase
  ready_const_a: assert property (psel_i && penable_i
    |-> pready_o)
    else $error("wait state inserted");
  err_range_a: assert property (access && paddr_i > `ADDR_IRQ_MASK
    |-> pslverr_o)
    else $error("unmapped address accepted");
  err_align_a: assert property (access && paddr_i[1:0] != 2'b00
    |-> pslverr_o)
    else $error("unaligned address accepted");
  err_clear_rd_a: assert property (access && !pwrite_i && paddr_i == `ADDR_CLEAR
    |-> pslverr_o)
    else $error("clear register read accepted");
  err_idle_a: assert property (!access
    |-> !pslverr_o)
    else $error("error outside access phase");
  err_mapped_a: assert property (access && pwrite_i && paddr_i == `ADDR_RUN_CTRL0
    |-> !pslverr_o)
    else $error("mapped write refused");
  rdata_idle_a: assert property (!(psel_i && !penable_i && !pwrite_i)
    |=> prdata_o == 32'h0000_0000)
    else $error("read data outside a read");
  rdata_cfg_a: assert property (psel_i && !penable_i && !pwrite_i && paddr_i == `ADDR_CFG_WORD
    |=> prdata_o == {16'h0000, $past(state.cfg)})
    else $error("config word read wrong");
  rdata_ctrl0_a: assert property (psel_i && !penable_i && !pwrite_i && paddr_i == `ADDR_RUN_CTRL0
    |=> prdata_o == {26'h000_0000, $past(state.ps), $past(state.soft_en)})
    else $error("control zero read wrong");
  rdata_count_a: assert property (psel_i && !penable_i && !pwrite_i && paddr_i == `ADDR_COUNT
    |=> prdata_o == {8'h00, $past(state.count)})
    else $error("count read wrong");
  rdata_status_a: assert property (psel_i && !penable_i && !pwrite_i && paddr_i == `ADDR_IRQ_STATUS
    |=> prdata_o == {30'h0000_0000, $past(state.irq_status)})
    else $error("status read wrong");

  timeout_c:  cover property (timeout);
  closed_c:   cover property (clr_closed);
  sleep_c:    cover property (mode == MODE_AWAKE && sleep_i);
  irq_c:      cover property (irq_o);
  open_clr_c: cover property (clr_hit && !clr_closed);
endmodule // wwdt_cfg_decode
`default_nettype wire

// >>> dv/testbench.sv
// self-checking apb bench for the windowed watchdog configuration decode block
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_cfg_defs.svh"
module testbench;
  import wwdt_cfg_pkg::*;
  logic         clk_sys_i = 1'b0;
  logic         reset_i   = 1'b1;
  logic         sleep_i   = 1'b0;
  logic         psel_i    = 1'b0;
  logic         penable_i = 1'b0;
  logic         pwrite_i  = 1'b0;
  logic [15:0]  cfg_word_i = `CFG_WORD_RESET;
  logic [11:0]  paddr_i   = 12'h000;
  logic [31:0]  pwdata_i  = 32'h0000_0000;
  logic [31:0]  prdata_o;
  logic [31:0]  rd;
  logic         pready_o;
  logic         pslverr_o;
  logic         wdt_reset_o;
  logic         irq_o;
  logic         err;
  logic         got;
  period_code_t period_code_o;
  int           errors     = 0;
  int           n_compared = 0;
  // {counting expected, sleep, software enable, config word}
  logic [18:0]  modes [7] = '{{3'b110, 16'hC7E4}, {3'b010, 16'hC7C4}, {3'b100, 16'hC7C4},
                              {3'b000, 16'hC7A4}, {3'b101, 16'hC7A4}, {3'b001, 16'hC784}, {3'b000, 16'hDFE4}};
  always #2 clk_sys_i = ~clk_sys_i;
  wwdt_cfg_decode i_wwdt_cfg_decode (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .cfg_word_i(cfg_word_i),
    .sleep_i(sleep_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .wdt_reset_o(wdt_reset_o), .irq_o(irq_o), .period_code_o(period_code_o));
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // request held until pready is sampled high, then released
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= wr;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      summarize();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // config is only taken after a reset, so each setup reboots the block
  task automatic boot(input logic [15:0] c);
    reset_i    <= 1'b1;
    cfg_word_i <= c;
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
  endtask
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    errors++;
    summarize();
  end
  initial begin
    boot(`CFG_WORD_RESET);
    chk("period_por", period_code_o, `PS_POR_VALUE);
    apb(1'b0, `ADDR_CFG_WORD, 32'h0);
    chk("cfg_word", rd, 32'h0000_FFFF);
    apb(1'b1, `ADDR_RUN_CTRL0, 32'h0000_0006);
    repeat (2) @(posedge clk_sys_i);
    chk("period_soft", period_code_o, 32'h3);
    apb(1'b1, `ADDR_RUN_CTRL1, 32'h0000_0002);
    apb(1'b0, `ADDR_RUN_CTRL1, 32'h0);
    chk("window_soft", rd[2:0], 32'h2);
    apb(1'b0, 12'h01C, 32'h0);
    chk("unmapped_err", err, 32'h1);
    apb(1'b0, `ADDR_CLEAR, 32'h0);
    chk("clear_read_err", err, 32'h1);
    // window 000 keeps the window closed for 7/8 of the period
    boot(16'hC064);
    chk("period_fixed", period_code_o, 32'h4);
    apb(1'b1, `ADDR_RUN_CTRL0, 32'h0000_000E);
    repeat (2) @(posedge clk_sys_i);
    chk("period_locked", period_code_o, 32'h4);
    apb(1'b1, `ADDR_RUN_CTRL1, 32'h0000_0007);
    apb(1'b0, `ADDR_RUN_CTRL1, 32'h0);
    chk("window_locked", rd[2:0], 32'h0);
    apb(1'b1, `ADDR_IRQ_MASK, 32'h0000_0002);
    got = 1'b0;
    apb(1'b1, `ADDR_CLEAR, `CLEAR_KEY);
    repeat (8) begin
      @(posedge clk_sys_i);
      if (wdt_reset_o === 1'b1) got = 1'b1;
    end
    chk("closed_clear_reset", got, 32'h1);
    chk("irq_raised", irq_o, 32'h1);
    apb(1'b0, `ADDR_IRQ_STATUS, 32'h0);
    chk("status_closed", rd[1], 32'h1);
    repeat (2) @(posedge clk_sys_i);
    chk("irq_cleared", irq_o, 32'h0);
    // code 10011 folds back onto the smallest divider
    boot(16'hC7F3);
    chk("period_fold", period_code_o, 32'h13);
    // one reference tick takes 8064 cycles, so wait a little longer
    for (int k = 0; k < 7; k++) begin
      sleep_i <= modes[k][17];
      boot(modes[k][15:0]);
      apb(1'b1, `ADDR_RUN_CTRL0, {31'h0, modes[k][16]});
      repeat (8200) @(posedge clk_sys_i);
      apb(1'b0, `ADDR_COUNT, 32'h0);
      chk("count_runs", rd != 32'h0, {31'h0, modes[k][18]});
    end
    summarize();
  end
endmodule // testbench
`default_nettype wire
